// ### hw/aiu_top.sv
// Axis interrupt unit: APB registers, six channels, one interrupt line
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module aiu_top #(
  parameter int NCHAN = 6,
  parameter int ADC_W = 12
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  wire logic [NCHAN-1:0]       pos_lim,
  input  wire logic [NCHAN-1:0]       neg_lim,
  input  wire logic [NCHAN-1:0]       estop,
  input  wire logic [NCHAN-1:0]       home,
  input  wire logic [NCHAN-1:0]       index_evt,
  input  wire logic [NCHAN-1:0]       enc_cmp_evt,
  input  wire logic [NCHAN-1:0]       timer_evt,
  input  wire logic [NCHAN-1:0]       adc_valid,
  input  wire logic [NCHAN*ADC_W-1:0] adc_result
);
  logic [6:0]       mask_reg  [NCHAN];
  logic [1:0]       dir_reg   [NCHAN];
  logic [ADC_W-1:0] level_reg [NCHAN];
  logic             gen_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             irq_reg;
  logic [7:0]       status_w  [NCHAN];
  logic [NCHAN-1:0] chan_pend;

  // Address decode; channel index lives in paddr[6:4]
  wire [2:0] ch_idx  = paddr[6:4];
  wire [7:0] wd_off  = paddr & 8'h0F;
  wire       ch_hit  = !paddr[7] && (ch_idx < 3'(NCHAN))
                       && (paddr[1:0] == 2'h0);
  wire       gen_hit = paddr == aiu_pkg::OFF_GEN;
  wire       pnd_hit = paddr == aiu_pkg::OFF_PEND;
  wire       hit     = ch_hit | gen_hit | pnd_hit;
  wire       is_mask = ch_hit && wd_off == aiu_pkg::OFF_MASK;
  wire       is_stat = ch_hit && wd_off == aiu_pkg::OFF_STATUS;
  wire       is_dir  = ch_hit && wd_off == aiu_pkg::OFF_DIR;
  wire       is_lvl  = ch_hit && wd_off == aiu_pkg::OFF_LEVEL;

  // Bus phases; the slave answers in the first access cycle
  wire setup = psel && !penable;
  wire done  = psel && penable && pready_reg;
  wire wr_ok = done && pwrite && hit;
  wire rd_st = done && !pwrite && is_stat;
  wire w1c   = done && pwrite && is_stat;

  // Read data selection
  wire [31:0] ch_word =
      is_mask ? {25'h0, mask_reg[ch_idx]} :
      is_stat ? {24'h0, status_w[ch_idx]} :
      is_dir  ? {30'h0, dir_reg[ch_idx]}  :
      is_lvl  ? {{(32-ADC_W){1'b0}}, level_reg[ch_idx]} : 32'h0;
  wire [31:0] rd_mux =
      ch_hit  ? ch_word :
      gen_hit ? {31'h0, gen_reg} :
      pnd_hit ? {{(32-NCHAN){1'b0}}, chan_pend} : 32'h0;

  // Bus answer flops; read data is caught in the setup cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !hit;
      if (setup && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // Global enable register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gen_reg <= aiu_pkg::RST_GEN;
    end else if (wr_ok && gen_hit) begin
      gen_reg <= pwdata[0];
    end
  end

  // Interrupt line, gated by the global enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= gen_reg && (|chan_pend);
    end
  end

  // Per-channel configuration and cause logic
  for (genvar c = 0; c < NCHAN; c++) begin : g_ch
    wire sel = ch_idx == 3'(c);
    // Read clear drops only the bits that were returned to software,
    // so a cause arriving after the setup cycle is not lost
    wire [7:0] clr = (rd_st && sel) ? prdata_reg[7:0] :
                     (w1c && sel)   ? pwdata[7:0] : 8'h00;

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        mask_reg[c]  <= aiu_pkg::RST_MASK;
        dir_reg[c]   <= aiu_pkg::RST_DIR;
        level_reg[c] <= aiu_pkg::RST_LEVEL;
      end else if (wr_ok && sel) begin
        if (is_mask) mask_reg[c] <= pwdata[6:0];
        if (is_dir)  dir_reg[c]  <= pwdata[1:0];
        if (is_lvl)  level_reg[c] <= aiu_pkg::aiu_clamp(pwdata[11:0]);
      end
    end

    // Channel slice; its causes clear only through clr
    aiu_chan #(.ADC_W(ADC_W)) u_chan (
      .mclk                  (mclk),
      .sys_rst               (sys_rst),
      .pos_lim               (pos_lim[c]),
      .neg_lim               (neg_lim[c]),
      .estop                 (estop[c]),
      .home                  (home[c]),
      .index_evt             (index_evt[c]),
      .enc_cmp_evt           (enc_cmp_evt[c]),
      .timer_evt             (timer_evt[c]),
      .adc_valid             (adc_valid[c]),
      .adc_result            (adc_result[c*ADC_W +: ADC_W]),
      .source_enable_mask    (mask_reg[c]),
      .adc_compare_direction (dir_reg[c]),
      .adc_level             (level_reg[c]),
      .cause_clear           (clr),
      .cause_status_word     (status_w[c]),
      .pending               (chan_pend[c])
    );
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  apb_answer_a: assert property (
    apb_setup_s ##1 psel && penable |-> pready)
    else $error("APB access not answered in first access cycle");
  irq_gate_a: assert property (!gen_reg |=> !irq)
    else $error("interrupt raised with global enable off");
  irq_follow_a: assert property (
    gen_reg && (|chan_pend) |=> irq)
    else $error("pending cause did not raise interrupt");
  mask_write_a: assert property (
    apb_setup_s ##1 apb_access_s ##0 pwrite && is_mask && ch_idx == 3'h0
    |=> mask_reg[0] == $past(pwdata[6:0]))
    else $error("mask write not stored");
  status_read_a: assert property (
    apb_setup_s ##0 !pwrite && is_stat && ch_idx == 3'h1
    |=> prdata == {24'h0, $past(status_w[1])})
    else $error("status word read back wrong");
  level_range_a: assert property (level_reg[1] <= 12'hFA0)
    else $error("compare level beyond scale");
  chan_split_a: assert property (
    wr_ok && is_mask && ch_idx == 3'h3 |=> $stable(mask_reg[4]))
    else $error("write leaked into another channel");

  // Completed write in the access phase
  sequence apb_write_s;
    apb_setup_s ##1 apb_access_s ##0 pwrite;
  endsequence

  // Configuration writes land in the addressed register only
  gen_write_a: assert property (
    apb_write_s ##0 gen_hit |=> gen_reg == $past(pwdata[0]))
    else $error("global enable write not stored");
  dir_write_a: assert property (
    apb_write_s ##0 is_dir && ch_idx == 3'h1
    |=> dir_reg[1] == $past(pwdata[1:0]))
    else $error("compare direction write not stored");
  level_clamp_a: assert property (
    apb_write_s ##0 is_lvl && ch_idx == 3'h1 && pwdata[11:0] > 12'hFA0
    |=> level_reg[1] == 12'hFA0)
    else $error("compare level not saturated");

  // Write-one clear drops the cause unless its source fires again
  w1c_clear_a: assert property (
    apb_write_s ##0 is_stat && ch_idx == 3'h2 && pwdata[0]
    && !pos_lim[2] |=> !status_w[2][0])
    else $error("written one did not clear the cause");

  // Line and pending summary follow the channel state
  irq_drop_a: assert property (!(|chan_pend) |=> !irq)
    else $error("interrupt held with nothing pending");
  pend_read_a: assert property (
    apb_setup_s ##0 !pwrite && pnd_hit
    |=> prdata == {{(32-NCHAN){1'b0}}, $past(chan_pend)})
    else $error("pending summary read back wrong");
endmodule : aiu_top

// ### hw/aiu_pkg.sv
// Constants shared by the axis interrupt unit and its channel slices
package aiu_pkg;
  // Sizes
  localparam int NCHAN   = 6;
  localparam int SRC_W   = 7;
  localparam int CAUSE_W = 8;
  localparam int ADC_W   = 12;
  localparam logic [11:0] ADC_LEVEL_MAX = 12'hFA0;
  // Register map: channel c at c * CH_STRIDE plus a word offset
  localparam logic [7:0] CH_STRIDE  = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DIR    = 8'h08;
  localparam logic [7:0] OFF_LEVEL  = 8'h0C;
  localparam logic [7:0] OFF_GEN    = 8'h60;
  localparam logic [7:0] OFF_PEND   = 8'h64;
  // Reset values
  localparam logic [6:0]  RST_MASK  = 7'h00;
  localparam logic [1:0]  RST_DIR   = 2'h0;
  localparam logic [11:0] RST_LEVEL = 12'h7D0;
  localparam logic        RST_GEN   = 1'b0;
  // Source-enable mask bits
  localparam int M_LIMIT = 0;
  localparam int M_ESTOP = 1;
  localparam int M_HOME  = 2;
  localparam int M_INDEX = 3;
  localparam int M_ENC   = 4;
  localparam int M_TIMER = 5;
  localparam int M_ADC   = 6;
  // Cause status bits
  localparam int C_POSLIM = 0;
  localparam int C_NEGLIM = 1;
  localparam int C_ESTOP  = 2;
  localparam int C_HOME   = 3;
  localparam int C_INDEX  = 4;
  localparam int C_ENC    = 5;
  localparam int C_TIMER  = 6;
  localparam int C_ADC    = 7;
  // ADC compare direction codes; bit 0 rising, bit 1 falling
  localparam logic [1:0] DIR_OFF  = 2'h0;
  localparam logic [1:0] DIR_RISE = 2'h1;
  localparam logic [1:0] DIR_FALL = 2'h2;
  localparam logic [1:0] DIR_BOTH = 2'h3;

  // Spread the seven source enables over the eight cause bits
  function automatic logic [7:0] aiu_expand(input logic [6:0] m);
    aiu_expand = {m[M_ADC], m[M_TIMER], m[M_ENC], m[M_INDEX],
                  m[M_HOME], m[M_ESTOP], m[M_LIMIT], m[M_LIMIT]};
  endfunction : aiu_expand

  // Keep a compare level inside the ADC result scale
  function automatic logic [11:0] aiu_clamp(input logic [11:0] v);
    aiu_clamp = (v > ADC_LEVEL_MAX) ? ADC_LEVEL_MAX : v;
  endfunction : aiu_clamp
endpackage : aiu_pkg

// ### hw/aiu_chan.sv
// One channel: source edge detection, ADC crossing and cause status
`timescale 1ns/1ps
module aiu_chan #(
  parameter int ADC_W = 12
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             pos_lim,
  input  wire logic             neg_lim,
  input  wire logic             estop,
  input  wire logic             home,
  input  wire logic             index_evt,
  input  wire logic             enc_cmp_evt,
  input  wire logic             timer_evt,
  input  wire logic             adc_valid,
  input  wire logic [ADC_W-1:0] adc_result,
  input  wire logic [6:0]       source_enable_mask,
  input  wire logic [1:0]       adc_compare_direction,
  input  wire logic [ADC_W-1:0] adc_level,
  input  wire logic [7:0]       cause_clear,
  output logic      [7:0]       cause_status_word,
  output logic                  pending
);
  logic [3:0] sw_reg;
  logic       above_reg;
  logic       seen_reg;
  logic [7:0] status_reg;

  // Switch levels become events on their active edge only
  wire [3:0] sw_now  = {home, estop, neg_lim, pos_lim};
  wire [3:0] sw_rise = sw_now & ~sw_reg;
  // First sample only primes the comparator, so no false crossing
  wire now_above = adc_result >= adc_level;
  wire adc_rise  = adc_valid & seen_reg & ~above_reg & now_above;
  wire adc_fall  = adc_valid & seen_reg & above_reg & ~now_above;
  wire adc_evt   = (adc_rise & adc_compare_direction[0]) |
                   (adc_fall & adc_compare_direction[1]);
  wire [7:0] evt = {adc_evt, timer_evt, enc_cmp_evt, index_evt,
                    sw_rise[3], sw_rise[2], sw_rise[1], sw_rise[0]};
  wire [7:0] en8 = aiu_pkg::aiu_expand(source_enable_mask);
  // Set wins over clear so an event in the clear cycle survives
  wire [7:0] status_next = (status_reg & ~cause_clear)
                         | (evt & en8);

  // Edge history and cause storage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_reg     <= 4'h0;
      above_reg  <= 1'b0;
      seen_reg   <= 1'b0;
      status_reg <= 8'h00;
    end else begin
      sw_reg     <= sw_now;
      status_reg <= status_next;
      if (adc_valid) begin
        above_reg <= now_above;
        seen_reg  <= 1'b1;
      end
    end
  end

  assign cause_status_word = status_reg;
  assign pending = |(status_reg & en8);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Samples are sparse, so the crossing is judged against the kept one
  sequence rise_cross_s;
    seen_reg && !above_reg ##0 adc_valid && now_above;
  endsequence

  all_causes_kept_a: assert property (
    (evt & en8) != 8'h00 |=> (status_reg & $past(evt & en8))
                            == $past(evt & en8))
    else $error("simultaneous causes not all recorded");
  adc_rise_fire_a: assert property (
    rise_cross_s ##0 adc_compare_direction[0] && source_enable_mask[6]
    |=> status_reg[7])
    else $error("rising ADC crossing not recorded");
  adc_off_quiet_a: assert property (
    adc_compare_direction == 2'h0 && !status_reg[7] |=> !status_reg[7])
    else $error("ADC cause set with compare off");
  read_clears_a: assert property (
    cause_clear[0] && !(evt[0] && en8[0]) |=> !status_reg[0])
    else $error("cause bit not cleared");
endmodule : aiu_chan

// ### test/aiu_host.sv
// Host software model: APB master reaching the interrupt unit
`timescale 1ns/1ps
module aiu_host (
  input  wire logic        mclk,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle at time zero
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
  end

  // One transfer; released address and write data go to inverted junk, not held values; pwrite keeps its value
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e, output bit to);
    to = 1'b1;
    q = 32'h00000000;
    e = 1'b0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        to = 1'b0;
        break;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : aiu_host

// ### test/tb.sv
// Self-checking bench for the axis interrupt unit
`timescale 1ns/1ps
module tb;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] pwdata, prdata;
  logic [5:0]  pos_lim = '0, neg_lim = '0, estop = '0, home = '0;
  logic [5:0]  index_evt = '0, enc_cmp_evt = '0, timer_evt = '0;
  logic [5:0]  adc_valid = '0;
  logic [71:0] adc_result = '0;
  int          failures = 0;
  int          cmp_count = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  aiu_top dut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .pos_lim(pos_lim),
    .neg_lim(neg_lim), .estop(estop), .home(home), .index_evt(index_evt),
    .enc_cmp_evt(enc_cmp_evt), .timer_evt(timer_evt),
    .adc_valid(adc_valid), .adc_result(adc_result));
  aiu_host host (.mclk(mclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  function automatic logic [7:0] ra(input int c, input logic [7:0] o);
    ra = 8'(c * 16) + o;
  endfunction : ra

  // Bus wrappers; a stuck handshake ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bit          to;
    host.xfer(1'b1, a, d, q, e, to);
    if (to) begin
      failures++;
      tally_and_finish();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe, input string n);
    logic [31:0] q;
    logic        e;
    bit          to;
    host.xfer(1'b0, a, 32'h00000000, q, e, to);
    if (to) begin
      failures++;
      tally_and_finish();
    end else begin
      chk(n, q, x);
      chk({n, " err"}, {31'h0, e}, {31'h0, xe});
    end
  endtask : rd

  // Sources: 0 +lim,1 -lim,2 estop,3 home,4 index,5 enc,6 timer
  task automatic fire(input int c, input logic [6:0] s);
    @(posedge mclk);
    {timer_evt[c], enc_cmp_evt[c], index_evt[c], home[c], estop[c],
     neg_lim[c], pos_lim[c]} <= s;
    @(posedge mclk);
    {timer_evt, enc_cmp_evt, index_evt, home, estop, neg_lim,
     pos_lim} <= '0;
    repeat (3) @(posedge mclk);
  endtask : fire

  task automatic adc(input int c, input logic [11:0] v);
    @(posedge mclk);
    adc_valid[c] <= 1'b1;
    adc_result[c*12 +: 12] <= v;
    @(posedge mclk);
    adc_valid <= '0;
    repeat (3) @(posedge mclk);
  endtask : adc

  task automatic t_reset;
    rd(ra(0, aiu_pkg::OFF_MASK), 32'h0, 1'b0, "mask");
    rd(ra(0, aiu_pkg::OFF_DIR), 32'h0, 1'b0, "dir");
    rd(ra(0, aiu_pkg::OFF_LEVEL), 32'h7D0, 1'b0, "level");
    rd(aiu_pkg::OFF_GEN, 32'h0, 1'b0, "enable");
    rd(8'h70, 32'h0, 1'b1, "unmapped");
    rd(8'h02, 32'h0, 1'b1, "unaligned");
  endtask : t_reset

  // Each channel keeps its own cause word
  task automatic t_chan;
    for (int c = 0; c < 6; c++) begin
      wr(ra(c, aiu_pkg::OFF_MASK), 32'h20);
      fire(c, 7'h40);
      rd(ra((c + 1) % 6, aiu_pkg::OFF_STATUS), 32'h0, 1'b0, "other");
      rd(ra(c, aiu_pkg::OFF_STATUS), 32'h40, 1'b0, "timer");
      rd(ra(c, aiu_pkg::OFF_STATUS), 32'h0, 1'b0, "cleared");
    end
  endtask : t_chan

  // Masked sources leave no cause behind
  task automatic t_mask;
    wr(ra(3, aiu_pkg::OFF_MASK), 32'h04);
    fire(3, 7'h68);
    rd(ra(3, aiu_pkg::OFF_STATUS), 32'h08, 1'b0, "home only");
    wr(ra(3, aiu_pkg::OFF_MASK), 32'h10);
    fire(3, 7'h68);
    rd(ra(3, aiu_pkg::OFF_STATUS), 32'h20, 1'b0, "enc only");
  endtask : t_mask

  // Simultaneous causes, then the global gate on the line
  task automatic t_multi;
    wr(ra(2, aiu_pkg::OFF_MASK), 32'h7F);
    fire(2, 7'h17);
    chk("irq gated", {31'h0, irq}, 32'h0);
    rd(aiu_pkg::OFF_PEND, 32'h04, 1'b0, "pending");
    wr(aiu_pkg::OFF_GEN, 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq on", {31'h0, irq}, 32'h1);
    rd(ra(2, aiu_pkg::OFF_STATUS), 32'h17, 1'b0, "multi");
    repeat (3) @(posedge mclk);
    chk("irq off", {31'h0, irq}, 32'h0);
  endtask : t_multi

  // Write-one clear, then the global enable dropped with a cause pending
  task automatic t_clear;
    fire(2, 7'h03);
    wr(ra(2, aiu_pkg::OFF_STATUS), 32'h01);
    rd(ra(2, aiu_pkg::OFF_STATUS), 32'h02, 1'b0, "w1c");
    fire(2, 7'h40);
    repeat (3) @(posedge mclk);
    chk("irq timer", {31'h0, irq}, 32'h1);
    wr(aiu_pkg::OFF_GEN, 32'h0);
    repeat (3) @(posedge mclk);
    chk("irq disabled", {31'h0, irq}, 32'h0);
    rd(ra(2, aiu_pkg::OFF_STATUS), 32'h40, 1'b0, "kept");
  endtask : t_clear

  // Level saturation and every crossing direction
  task automatic t_adc;
    wr(ra(1, aiu_pkg::OFF_MASK), 32'h40);
    wr(ra(1, aiu_pkg::OFF_LEVEL), 32'hFFF);
    rd(ra(1, aiu_pkg::OFF_LEVEL), 32'hFA0, 1'b0, "clamp");
    wr(ra(1, aiu_pkg::OFF_LEVEL), 32'h7D0);
    for (int d = 1; d < 4; d++) begin
      wr(ra(1, aiu_pkg::OFF_DIR), 32'(d));
      adc(1, 12'h064);
      rd(ra(1, aiu_pkg::OFF_STATUS), 32'h0, 1'b0, "below");
      adc(1, 12'hBB8);
      rd(ra(1, aiu_pkg::OFF_STATUS), d[0] ? 32'h80 : 32'h0, 1'b0,
         "rise");
      adc(1, 12'h064);
      rd(ra(1, aiu_pkg::OFF_STATUS), d[1] ? 32'h80 : 32'h0, 1'b0,
         "fall");
    end
    // Direction code 0 keeps the compare source silent
    wr(ra(1, aiu_pkg::OFF_DIR), 32'h0);
    adc(1, 12'hBB8);
    rd(ra(1, aiu_pkg::OFF_STATUS), 32'h0, 1'b0, "off");
  endtask : t_adc

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_chan();
    t_mask();
    t_multi();
    t_clear();
    t_adc();
    tally_and_finish();
  end
endmodule : tb
